// ===== verilog/nsoc_consts.svh
// constants of the negative sequence overcurrent timing block
`ifndef NSOC_CONSTS_SVH
`define NSOC_CONSTS_SVH

// timing: clock period and delay tick, both in ns
`define NSOC_CLK_NS      25
`define NSOC_TICK_NS     1000000

// setting ranges, threshold in percent, multiplier in hundredths, delays in ms
`define NSOC_THR_MIN     16'h000A
`define NSOC_THR_MAX     16'h03E8
`define NSOC_TMS_MIN     16'h0005
`define NSOC_TMS_MAX     16'h05DC
`define NSOC_DLY_MIN     16'h0028
`define NSOC_RST_MIN     16'h003C
`define NSOC_DLY_MAX     16'h EA60

// reset values of the computed delays, in ms
`define NSOC_OPER_RST    16'h0064
`define NSOC_RSTD_RST    16'h0064

// fixed point: magnitude in 0.1 % steps, ratio in q8.8, curve terms in q16
`define NSOC_PCT_SCALE   16'h000A
`define NSOC_RATIO_ONE   13'h0100
`define NSOC_RATIO_MAX   13'h1400
`define NSOC_Q16_ONE     26'h001_0000
`define NSOC_LN_SCALE    22'h38C
`define NSOC_TMS_DIV     16'h0640

`endif

// ===== verilog/nsoc_pkg.sv
// types of the negative sequence overcurrent timing block
package nsoc_pkg;

  typedef enum logic [3:0] {
    OP_OFF           = 4'h0,
    FIXED_DELAY_MODE = 4'h1,
    IEC_INV          = 4'h2,
    IEC_VERY_INV     = 4'h3,
    IEC_EXT_INV      = 4'h4,
    IEC_LONG_INV     = 4'h5,
    ANSI_INV         = 4'h6,
    ANSI_MOD_INV     = 4'h7,
    ANSI_VERY_INV    = 4'h8,
    ANSI_EXT_INV     = 4'h9,
    ANSI_LONG_INV    = 4'hA,
    ANSI_LVERY_INV   = 4'hB,
    ANSI_LEXT_INV    = 4'hC
  } nsoc_op_e;

  typedef enum logic [1:0] {
    ALPHA_P02 = 2'h0,
    ALPHA_1   = 2'h1,
    ALPHA_2   = 2'h2
  } nsoc_alpha_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RATIO = 2'b01,
    ST_CURVE = 2'b11,
    ST_SCALE = 2'b10
  } nsoc_state_e;

  typedef struct packed {
    nsoc_op_e    operation_select;
    logic [10:0] start_threshold_pct;
    logic [10:0] curve_time_multiplier;
    logic [15:0] min_inverse_delay;
    logic [15:0] fixed_operate_delay;
    logic [15:0] inverse_reset_delay;
  } nsoc_cfg_s;

  // k, c and kr in 1/16 ms, alpha as code
  typedef struct packed {
    logic [23:0] k;
    logic [15:0] c;
    logic [23:0] kr;
    nsoc_alpha_e alpha;
  } nsoc_curve_s;

endpackage : nsoc_pkg

// ===== verilog/nsoc_div.sv
// sequential restoring divider, one quotient bit per enabled clock
`timescale 1ns/100ps
module nsoc_div #(
  parameter int W = 48
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quo
);
  localparam int CW = $clog2(W + 1);

  generate
    if (W < 8) begin : g_bad_width
      $error("nsoc_div: W must be at least 8");
    end
  endgenerate

  logic [W-1:0]  rem;
  logic [W-1:0]  dvs;
  logic [CW-1:0] cnt;

  wire logic [W:0] shifted = {rem, quo[W-1]};
  wire logic [W:0] diff    = shifted - {1'b0, dvs};
  wire logic       take    = ~diff[W];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rem  <= '0;
      dvs  <= '0;
      quo  <= '0;
      cnt  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy) begin
        rem  <= '0;
        dvs  <= den;
        quo  <= num;
        cnt  <= CW'(W);
        busy <= 1'b1;
      end else if (busy) begin
        rem  <= take ? diff[W-1:0] : shifted[W-1:0];
        quo  <= {quo[W-2:0], take};
        cnt  <= cnt - 1'b1;
        busy <= (cnt != 1);
        done <= (cnt == 1);
      end
    end
  end
endmodule : nsoc_div

// ===== verilog/nsoc_timing.sv
// timing and decision logic of negative sequence overcurrent protection
`timescale 1ns/100ps
`include "nsoc_consts.svh"

// Summary of operation
// [R1] The only measured input is the negative sequence magnitude sample.
// [R2] The operation selector picks off, fixed delay or one of eleven curves.
// [R3] The start threshold is a percentage clamped to 10..1000.
// [R4] The time multiplier, clamped to 0.05..15, scales inverse curves only.
// [R5] Inverse operate delay never falls below the minimum delay setting.
// [R6] In fixed delay mode the operate delay is the fixed delay setting.
// [R7] Inverse curves hold their timer for a reset delay after dropout.
// [R8] Pickup shows while started and operate once the delay has elapsed.
// [R9] The block input disables pickup, timers and operate while it is high; the delay computation still runs.
// [R10] General pickup and operate combine the flags with the block input.
// [R11] Inverse time is tms*(k/(r^a-1)+c), with r held flat above twenty.
// [R12] IEC curves reset after the reset delay, ANSI after tms*kr/(1-r^2).
// [R13] Fixed mode operates after the fixed delay while above threshold.
// [R14] Off or blocked clears all timers and holds every flag low.
// [R15] Timers count 1 ms ticks and the delay is recomputed per sample.
module nsoc_timing #(
  parameter int MAG_W     = 16,
  parameter int MS_CYCLES =
    (`NSOC_TICK_NS + `NSOC_CLK_NS - 1) / `NSOC_CLK_NS
) (
  input  wire logic                sys_clk,
  input  wire logic                resetn,
  input  wire logic                ce,
  input  wire nsoc_pkg::nsoc_cfg_s cfg,
  input  wire logic [MAG_W-1:0]    neg_seq_magnitude,
  input  wire logic                sample_valid,
  input  wire logic                block_input,
  output logic                     pickup_flag,
  output logic                     operate_flag,
  output logic                     general_pickup,
  output logic                     general_operate,
  output logic [15:0]              operate_delay_ms,
  output logic                     calc_busy
);
  import nsoc_pkg::*;

  localparam int DW = 48;
  localparam int TW = $clog2(MS_CYCLES + 1);

  generate
    if (MAG_W < 8 || MAG_W > 24 || MS_CYCLES < 1) begin : g_bad_param
      $error("nsoc_timing: MAG_W must be 8..24 and MS_CYCLES at least 1");
    end
  endgenerate

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp16

  function automatic logic [3:0] msb13(input logic [12:0] v);
    msb13 = 4'h0;
    for (int i = 0; i < 13; i++) begin
      if (v[i]) msb13 = 4'(i);
    end
  endfunction : msb13

  function automatic nsoc_curve_s curve_lookup(input nsoc_op_e op);
    case (op)
      IEC_INV:        curve_lookup = '{24'h00_08C0, 16'h0000, 24'h00_0000, ALPHA_P02};
      IEC_VERY_INV:   curve_lookup = '{24'h03_4BC0, 16'h0000, 24'h00_0000, ALPHA_1};
      IEC_EXT_INV:    curve_lookup = '{24'h13_8800, 16'h0000, 24'h00_0000, ALPHA_2};
      IEC_LONG_INV:   curve_lookup = '{24'h1D_4C00, 16'h0000, 24'h00_0000, ALPHA_1};
      ANSI_INV:       curve_lookup = '{24'h00_008A, 16'h0128, 24'h00_1CC0, ALPHA_P02};
      ANSI_MOD_INV:   curve_lookup = '{24'h00_0338, 16'h0720, 24'h01_2F20, ALPHA_P02};
      ANSI_VERY_INV:  curve_lookup = '{24'h04_C9A0, 16'h1EB0, 24'h05_4600, ALPHA_2};
      ANSI_EXT_INV:   curve_lookup = '{24'h06_E280, 16'h079B, 24'h07_1AC0, ALPHA_2};
      ANSI_LONG_INV:  curve_lookup = '{24'h00_0560, 16'h0B90, 24'h01_1F80, ALPHA_P02};
      ANSI_LVERY_INV: curve_lookup = '{24'h06_F860, 16'h2C80, 24'h03_4940, ALPHA_2};
      ANSI_LEXT_INV:  curve_lookup = '{24'h0F_A460, 16'h0FA0, 24'h07_5300, ALPHA_2};
      default:        curve_lookup = '{24'h00_0000, 16'h0000, 24'h00_0000, ALPHA_1};
    endcase
  endfunction : curve_lookup

  // settings, clamped to their legal ranges
  wire logic [15:0] thr_pct = clamp16({5'h00, cfg.start_threshold_pct},
                                      `NSOC_THR_MIN, `NSOC_THR_MAX); // R3
  wire logic [15:0] tms     = clamp16({5'h00, cfg.curve_time_multiplier},
                                      `NSOC_TMS_MIN, `NSOC_TMS_MAX); // R4
  wire logic [15:0] min_d   = clamp16(cfg.min_inverse_delay,
                                      `NSOC_DLY_MIN, `NSOC_DLY_MAX);
  wire logic [15:0] fix_d   = clamp16(cfg.fixed_operate_delay,
                                      `NSOC_DLY_MIN, `NSOC_DLY_MAX);
  wire logic [15:0] rst_d   = clamp16(cfg.inverse_reset_delay,
                                      `NSOC_RST_MIN, `NSOC_DLY_MAX);

  // operation decode
  wire nsoc_op_e    op       = cfg.operation_select;
  wire logic        op_fixed = (op == FIXED_DELAY_MODE); // R2
  wire logic        op_iec   = op inside {[IEC_INV:IEC_LONG_INV]}; // R2
  wire logic        op_ansi  = op inside {[ANSI_INV:ANSI_LEXT_INV]}; // R2
  wire logic        op_inv   = op_iec | op_ansi;
  wire logic        active   = (op_fixed | op_inv) & ~block_input; // R9 R14
  wire nsoc_curve_s curve    = curve_lookup(op);

  // threshold comparison on the latest sample
  logic [MAG_W-1:0] mag;
  wire logic [23:0] mag24  = 24'(mag);
  wire logic [31:0] gs_raw = thr_pct * `NSOC_PCT_SCALE;
  wire logic [23:0] gs24   = gs_raw[23:0];
  wire logic        picked = active & (mag24 > gs24); // R8 R13

  // delay computation
  nsoc_state_e      state;
  logic             calc_above;
  logic [15:0]      oper_calc;
  logic [15:0]      rstd_calc;
  logic             div_start;
  logic [DW-1:0]    div_num;
  logic [DW-1:0]    div_den;
  logic             div_done;
  logic [DW-1:0]    div_quo;

  nsoc_div #(.W(DW)) u_div (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .ce      (ce),
    .start   (div_start),
    .num     (div_num),
    .den     (div_den),
    .busy    (),
    .done    (div_done),
    .quo     (div_quo)
  );

  wire logic [23:0] next_mag24 = 24'(neg_seq_magnitude);
  wire logic        next_above = next_mag24 > gs24;
  wire logic [12:0] ratio = (div_quo > DW'(`NSOC_RATIO_MAX)) ?
                            `NSOC_RATIO_MAX : div_quo[12:0]; // R11
  wire logic [25:0] r2 = 26'(ratio) * 26'(ratio);
  wire logic [3:0]  rmsb  = msb13(ratio);
  wire logic [12:0] rnorm = ratio << (4'd12 - rmsb);
  wire logic [10:0] lg2   = {3'(rmsb - 4'd8), rnorm[11:4]};
  wire logic [21:0] ln_p  = 22'(lg2) * `NSOC_LN_SCALE;
  wire logic [25:0] den_p02 = 26'(ln_p[21:8]);
  wire logic [25:0] den_a1  = {5'h00, ratio - `NSOC_RATIO_ONE, 8'h00};
  wire logic [25:0] den_a2  = calc_above ? r2 - `NSOC_Q16_ONE
                                         : `NSOC_Q16_ONE - r2; // R12
  wire logic [25:0] den_sel = !calc_above ? den_a2 :
                              (curve.alpha == ALPHA_P02) ? den_p02 :
                              (curve.alpha == ALPHA_1) ? den_a1 : den_a2;
  wire logic [25:0] den_nz  = (den_sel == '0) ? 26'h1 : den_sel;
  wire logic [23:0] k_sel   = calc_above ? curve.k : curve.kr;
  wire logic        need_calc = op_inv & (calc_above | op_ansi);
  wire logic [DW-1:0] qc_sum = div_quo +
                               DW'(calc_above ? curve.c : 16'h0000);
  wire logic [31:0] qc_sat = (qc_sum[DW-1:32] != '0) ? '1 : qc_sum[31:0];
  wire logic [15:0] res_ms = (div_quo[DW-1:16] != '0) ? '1 : div_quo[15:0];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state      <= ST_IDLE;
      mag        <= '0;
      calc_above <= 1'b0;
      div_start  <= 1'b0;
      div_num    <= '0;
      div_den    <= '0;
      oper_calc  <= `NSOC_OPER_RST;
      rstd_calc  <= `NSOC_RSTD_RST;
    end else if (ce) begin
      div_start <= 1'b0;
      if (sample_valid) mag <= neg_seq_magnitude; // R1
      unique case (state)
        ST_IDLE: if (sample_valid) begin // R15
          calc_above <= next_above;
          div_num    <= DW'({next_mag24, 8'h00});
          div_den    <= DW'(gs24);
          div_start  <= 1'b1;
          state      <= ST_RATIO;
        end
        ST_RATIO: if (div_done) begin
          div_num   <= DW'({k_sel, 16'h0000}); // R11 R12
          div_den   <= DW'(den_nz);
          div_start <= need_calc;
          state     <= need_calc ? ST_CURVE : ST_IDLE;
        end
        ST_CURVE: if (div_done) begin
          div_num   <= DW'(qc_sat) * DW'(tms); // R4
          div_den   <= DW'(`NSOC_TMS_DIV);
          div_start <= 1'b1;
          state     <= ST_SCALE;
        end
        ST_SCALE: if (div_done) begin
          if (calc_above) oper_calc <= res_ms;
          else rstd_calc <= res_ms;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // effective delays
  wire logic [15:0] inv_d  = (oper_calc < min_d) ? min_d : oper_calc; // R5
  wire logic [15:0] oper_eff = op_fixed ? fix_d : inv_d; // R6 R13
  wire logic [15:0] rst_eff  = op_ansi ? rstd_calc : rst_d; // R7 R12

  // millisecond tick
  logic [TW-1:0] tick_cnt;
  wire logic     tick = (tick_cnt == TW'(MS_CYCLES - 1)); // R15

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) tick_cnt <= '0;
    else if (ce) tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
  end

  // operate and reset timers
  logic [15:0] op_cnt;
  logic [15:0] rs_cnt;
  wire logic [15:0] op_inc = (op_cnt == 16'hFFFF) ? op_cnt : op_cnt + 1'b1;
  wire logic [15:0] rs_inc = rs_cnt + 1'b1;
  wire logic rs_expire = (rs_inc >= rst_eff);
  wire logic [15:0] next_op_cnt =
    !active || (!picked && op_fixed) ? 16'h0000 : // R14 R13
    !tick ? op_cnt :
    picked ? op_inc :
    (op_cnt != 16'h0000 && rs_expire) ? 16'h0000 : op_cnt; // R7
  wire logic [15:0] next_rs_cnt =
    !active || picked || op_fixed || op_cnt == 16'h0000 ? 16'h0000 :
    !tick ? rs_cnt :
    rs_expire ? 16'h0000 : rs_inc; // R7 R14
  wire logic next_operate = picked & (op_cnt >= oper_eff); // R8

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      op_cnt <= '0;
      rs_cnt <= '0;
    end else if (ce) begin
      op_cnt <= next_op_cnt;
      rs_cnt <= next_rs_cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pickup_flag      <= 1'b0;
      operate_flag     <= 1'b0;
      general_pickup   <= 1'b0;
      general_operate  <= 1'b0;
      operate_delay_ms <= '0;
    end else if (ce) begin
      pickup_flag      <= picked; // R8
      operate_flag     <= next_operate; // R8
      general_pickup   <= picked & ~block_input; // R10
      general_operate  <= next_operate & ~block_input; // R10
      operate_delay_ms <= oper_eff;
    end
  end

  assign calc_busy = (state != ST_IDLE);
endmodule : nsoc_timing

// ===== verification/nsoc_timing_monitor.sv
// checker bound to the negative sequence overcurrent timing block
`timescale 1ns/100ps
module nsoc_monitor #(
  parameter int MAG_W     = 16,
  parameter int MS_CYCLES = 10
) (
  input wire logic                sys_clk,
  input wire logic                resetn,
  input wire logic                ce,
  input wire nsoc_pkg::nsoc_cfg_s cfg,
  input wire logic [MAG_W-1:0]    neg_seq_magnitude,
  input wire logic                sample_valid,
  input wire logic                block_input,
  input wire logic                pickup_flag,
  input wire logic                operate_flag,
  input wire logic                general_pickup,
  input wire logic                general_operate,
  input wire logic [15:0]         operate_delay_ms,
  input wire logic                calc_busy
);
  import nsoc_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  wire logic [3:0]  op    = cfg.operation_select;
  wire logic        act   = op inside {[4'h1:4'hC]};
  wire logic        inv   = op inside {[4'h2:4'hC]};
  wire logic [31:0] thr10 = 32'(cfg.start_threshold_pct) * 32'h0000_000A;
  wire logic        above = 32'(neg_seq_magnitude) > thr10;
  wire logic        smp   = ce && sample_valid && act && !block_input &&
                            cfg.start_threshold_pct inside {[11'h00A:11'h3E8]};
  wire logic        fixed = op == 4'h1 && cfg.fixed_operate_delay >= 16'h0028;
  wire logic [31:0] d_lo  = (32'(cfg.fixed_operate_delay) - 1) * MS_CYCLES;
  logic [31:0] pu_cyc;
  // ce cycles spent picked up, for the fixed delay window
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) pu_cyc <= '0;
    else if (ce) pu_cyc <= pickup_flag ? pu_cyc + 1 : '0;
  end
  sequence s_hold;
    ce && !sample_valid && !block_input && act && $stable(cfg);
  endsequence
  a_block_clears: assert property (ce && block_input |=> !pickup_flag &&
    !operate_flag && !general_pickup && !general_operate)
    else $error("flags stay up while blocked");
  a_off_clears: assert property (ce && !act |=> !pickup_flag && !operate_flag)
    else $error("flags stay up while off");
  a_gen_operate: assert property (general_operate == operate_flag)
    else $error("general operate differs from operate");
  a_gen_pickup: assert property (general_pickup |-> pickup_flag)
    else $error("general pickup without pickup");
  a_op_needs_pu: assert property (operate_flag |-> pickup_flag)
    else $error("operate without pickup");
  a_pickup_rise: assert property (smp && above ##1 s_hold ##1 s_hold |=> pickup_flag)
    else $error("no pickup above threshold");
  a_pickup_drop: assert property (smp && !above ##1 s_hold ##1 s_hold |=> !pickup_flag)
    else $error("pickup at or below threshold");
  a_calc_start: assert property (smp && inv && !calc_busy |=> calc_busy)
    else $error("sample did not start a computation");
  a_busy_bound: assert property ($rose(calc_busy) |-> ##[1:1000] !calc_busy)
    else $error("computation never ends");
  a_fixed_time: assert property ($rose(operate_flag) && fixed |->
    pu_cyc + 1 >= d_lo && pu_cyc <= d_lo + 2 * MS_CYCLES + 3)
    else $error("fixed trip outside its window");
  c_trip: cover property ($rose(operate_flag));
  c_blocked: cover property (block_input && pickup_flag);
  c_calc: cover property ($fell(calc_busy));
endmodule : nsoc_monitor

bind nsoc_timing nsoc_monitor #(.MAG_W(MAG_W), .MS_CYCLES(MS_CYCLES)) u_mon (
  .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .cfg(cfg),
  .neg_seq_magnitude(neg_seq_magnitude), .sample_valid(sample_valid),
  .block_input(block_input), .pickup_flag(pickup_flag),
  .operate_flag(operate_flag), .general_pickup(general_pickup),
  .general_operate(general_operate), .operate_delay_ms(operate_delay_ms),
  .calc_busy(calc_busy));

// ===== verification/nsoc_source.sv
// upstream magnitude source and user blocking logic
`timescale 1ns/100ps
module nsoc_source #(
  parameter int GAP = 200
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] mag_req,
  input  wire logic        blk_req,
  output logic [15:0]      neg_seq_magnitude,
  output logic             sample_valid,
  output logic             block_input
);
  int          cnt;
  logic [15:0] last;
  // one magnitude every GAP cycles; data off the strobe is scrambled
  always @(negedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      last <= 16'h0000;
      sample_valid <= 1'b0;
      neg_seq_magnitude <= 16'h0000;
      block_input <= 1'b0;
    end else begin
      block_input <= blk_req;
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      sample_valid <= cnt == GAP - 1;
      neg_seq_magnitude <= (cnt == GAP - 1) ? mag_req : ~last;
      last <= (cnt == GAP - 1) ? mag_req : last;
    end
  end
endmodule : nsoc_source

// ===== verification/tb_nsoc_timing.sv
// self-checking bench of the negative sequence overcurrent timing block
`timescale 1ns/100ps
module tb_nsoc_timing;
  import nsoc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        ce      = 1'b1;
  logic        blk_req = 1'b0;
  logic [15:0] mag_req = 16'h0000;
  nsoc_cfg_s   cfg;
  logic [15:0] neg_seq_magnitude, operate_delay_ms;
  logic        sample_valid, block_input, pickup_flag, operate_flag;
  logic        general_pickup, general_operate, calc_busy;
  logic [31:0] lfsr = 32'h0001_7737;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          t;
  longint      e;
  nsoc_op_e    ops[5] = '{IEC_VERY_INV, IEC_EXT_INV, ANSI_VERY_INV,
                          IEC_VERY_INV, IEC_LONG_INV};
  int          tmss[5] = '{100, 100, 50, 5, 1500};
  int          mags[5] = '{5000, 15000, 1000, 10000, 600};

  always #12.5 sys_clk = ~sys_clk;

  nsoc_source u_src (.sys_clk(sys_clk), .resetn(resetn), .mag_req(mag_req),
    .blk_req(blk_req), .neg_seq_magnitude(neg_seq_magnitude),
    .sample_valid(sample_valid), .block_input(block_input));
  nsoc_timing #(.MAG_W(16), .MS_CYCLES(10)) u_dut (
    .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .cfg(cfg),
    .neg_seq_magnitude(neg_seq_magnitude), .sample_valid(sample_valid),
    .block_input(block_input), .pickup_flag(pickup_flag),
    .operate_flag(operate_flag), .general_pickup(general_pickup),
    .general_operate(general_operate),
    .operate_delay_ms(operate_delay_ms), .calc_busy(calc_busy));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // curve delay in ms from integer math, clamped at twenty times threshold
  function automatic longint model_ms(nsoc_op_e op, longint tms, m, g);
    longint k, d;
    k = op == IEC_VERY_INV ? 13500 : op == IEC_EXT_INV ? 80000 :
        op == ANSI_VERY_INV ? 19610 : 120000;
    if (m > 20 * g) m = 20 * g;
    if (op == IEC_EXT_INV || op == ANSI_VERY_INV) d = k * g * g / (m * m - g * g);
    else d = k * g / (m - g);
    d = tms * (d + (op == ANSI_VERY_INV ? 491 : 0)) / 100;
    return d < 40 ? 40 : (d > 65535 ? 65535 : d);
  endfunction : model_ms

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp, input int tol = 0);
    n_checks++;
    if ((^seen === 1'bx) || seen > exp + tol || seen + tol < exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  task automatic set_cfg(input logic [3:0] op, input int thr, tms, dly, mag);
    @(negedge sys_clk);
    cfg <= '{nsoc_op_e'(op), 11'(thr), 11'(tms), 16'h0028, 16'(dly), 16'h003C};
    mag_req <= 16'(mag);
  endtask : set_cfg

  // returns at the edge that takes the requested magnitude
  task automatic next_smp();
    for (int i = 0; i < 450; i++) begin
      @(posedge sys_clk);
      if (sample_valid && ce && neg_seq_magnitude == mag_req) break;
    end
  endtask : next_smp

  task automatic edges(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : edges

  task automatic time_op(output int n);
    n = 0;
    #1;
    while (operate_flag !== 1'b1 && n < 2000) begin
      edges(1);
      n++;
    end
  endtask : time_op

  initial begin
    cfg = '{OP_OFF, 11'h032, 11'h064, 16'h0064, 16'h0064, 16'h0064};
    repeat (4) @(negedge sys_clk);
    check("reset outputs", {pickup_flag, operate_flag, general_pickup,
      general_operate, calc_busy, operate_delay_ms}, 0);
    resetn <= 1'b1;
    set_cfg(4'h1, 50, 100, 40, 501);
    next_smp();
    edges(2);
    check("pickup above", pickup_flag, 1);
    time_op(t);
    check("fixed trip cycles", t, 405, 12);
    check("fixed delay", operate_delay_ms, 40);
    check("general trip", general_operate, 1);
    $display("test fixed delay done");
    @(negedge sys_clk);
    blk_req <= 1'b1;
    edges(4);
    check("blocked", {pickup_flag, operate_flag, general_pickup}, 0);
    @(negedge sys_clk);
    blk_req <= 1'b0;
    edges(4);
    check("unblocked", {general_pickup, operate_flag}, 2'b10);
    set_cfg(4'h1, 50, 100, 40, 500);
    next_smp();
    edges(2);
    check("boundary", {pickup_flag, operate_flag}, 0);
    $display("test block and boundary done");
    for (int i = 0; i < 14; i++) begin
      set_cfg(4'(i), 50, 100, 60000, 2000);
      next_smp();
      edges(2);
      check("mode pickup", pickup_flag, i inside {[1:12]});
    end
    for (int i = 0; i < 12; i++) begin
      t = 10 + rnd() % 991;
      e = rnd() % 11000;
      set_cfg(4'h1, t, 100, 60000, e);
      next_smp();
      edges(2);
      check("random pickup", pickup_flag, e > t * 10);
    end
    $display("test modes and thresholds done");
    for (int i = 0; i < 5; i++) begin
      set_cfg(ops[i], 50, tmss[i], 100, mags[i]);
      next_smp();
      next_smp();
      repeat (300) begin
        @(negedge sys_clk);
        ce <= rnd() > 32'h8000_0000;
      end
      @(negedge sys_clk);
      ce <= 1'b1;
      for (t = 0; t < 1000 && calc_busy !== 1'b0; t++) edges(1);
      edges(2);
      e = model_ms(ops[i], tmss[i], mags[i], 500);
      check("inverse delay", operate_delay_ms, e, e / 32 + 2);
    end
    $display("test inverse delays done");
    // off with a quiet sample clears the timer left by the curve tests
    set_cfg(4'h0, 50, 5, 100, 0);
    next_smp();
    set_cfg(4'h3, 50, 5, 100, 10000);
    next_smp();
    set_cfg(4'h3, 50, 5, 100, 0);
    next_smp();
    set_cfg(4'h3, 50, 5, 100, 10000);
    next_smp();
    time_op(t);
    check("resumed trip cycles", t, 202, 25);
    $display("test reset hold done");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
endmodule : tb_nsoc_timing
